//--- rtl/rtsc_pkg.sv
package rtsc_pkg;
	// ----------------------------------------
	// register map (word offsets as byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_GAIN = 8'h04;
	localparam logic [7:0] ADDR_BLACK = 8'h08;
	localparam logic [7:0] ADDR_EXPOSURE = 8'h0c;
	localparam logic [7:0] ADDR_PERIOD = 8'h10;
	localparam logic [7:0] ADDR_PRETRIG = 8'h14;
	localparam logic [7:0] ADDR_DEPTH = 8'h18;
	localparam logic [7:0] ADDR_CMD = 8'h1c;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_STAMP = 8'h24;
	localparam logic [7:0] ADDR_TIME = 8'h28;
	localparam logic [7:0] ADDR_APPLY = 8'h2c;
	localparam logic [7:0] ADDR_SYNC_TMO = 8'h30;
	localparam logic [7:0] ADDR_CONTRAST = 8'h34;
	// ctrl bit positions
	localparam int CTRL_CIRC = 0;
	localparam int CTRL_SYNC_IN = 1;
	localparam int CTRL_TCODE = 2;
	localparam int CTRL_OUT_ARM = 3;
	localparam int CTRL_ARM_LOW = 4;
	localparam int CTRL_LOWLIGHT = 5;
	localparam int CTRL_GAIN_LIMIT4 = 6;
	// command bits
	localparam int CMD_START = 0;
	localparam int CMD_STOP = 1;
	// ----------------------------------------
	// limits and reset values
	// ----------------------------------------
	localparam logic [1:0] GAIN_STEP_MAX = 2'h3;
	localparam logic [7:0] BLACK_MAX = 8'hff;
	localparam logic [9:0] LOWLIGHT_EXP_MAX_MS = 10'h3ff;
	localparam logic [15:0] NORMAL_EXP_MAX_US = 16'h03e8;
	localparam int CLK_HZ = 50000000;
	localparam int US_CYCLES = CLK_HZ / 1000000;
	localparam int MS_CYCLES = CLK_HZ / 1000;
	localparam int TCODE_BIT_MS = 10;
	localparam int TCODE_BIT_CYCLES = TCODE_BIT_MS * MS_CYCLES;
	localparam int TCODE_ONE_MS = 5;
	localparam int TCODE_MARK_MS = 8;
	localparam logic [31:0] PERIOD_RESET = 32'h0000c350;
	localparam logic [31:0] SYNC_TMO_RESET = 32'h02faf080;
	localparam logic [15:0] EXP_RESET = 16'h0064;
	localparam logic [7:0] BLACK_RESET = 8'h10;
	localparam logic [7:0] CONTRAST_RESET = 8'h80;
	localparam logic [15:0] DEPTH_RESET = 16'h0400;
	localparam logic [15:0] PRETRIG_RESET = 16'h0200;

	typedef enum logic [2:0] {
		REC_IDLE = 3'b000,
		REC_FILL = 3'b001,
		REC_ARMED = 3'b011,
		REC_POST = 3'b010,
		REC_DONE = 3'b110
	} rtsc_rec_type;
endpackage : rtsc_pkg

//--- rtl/rtsc_top.sv
// How it works
// - gain is one of four steps, top step 8x or 4x by model
// - black level 0..255 written, zero-dark offset output
// - low-light mode stretches exposure to ms, values written while it is on capped at 1023 ms
// - any recording start drops low-light mode
// - sync-in enabled without pulses records nothing and flags timeout
// - time-code input demodulated into pulse widths and decoded
// - time shown as day ttt then hh:mm:ss in bcd
// - free-running frame timebase restarts at each one-second marker
// - one output pin carries exposure sync or ready-for-trigger
// - exposure sync high during each frame exposure
// - ready-for-trigger asserted while armed in circular mode
// - ready-for-trigger polarity selectable, exposure sync unaffected
// - non-circular records until buffer full then stops
// - non-circular start only from host command
// - circular ring buffer keeps pre-trigger count, rest post-trigger
// - trigger-relative stamps, first frame after trigger is zero
// - circular start from switch or host start
// - circular trigger from switch, external input or host stop
// - state led flashes while armed, stops at trigger
// - complete only after all post-trigger frames
// - buffer depth and rate latch only on apply, others at once
module rtsc_top #(
	parameter int DEPTH_W = 16,
	parameter logic [31:0] TCODE_BIT_CYC = 32'(rtsc_pkg::TCODE_BIT_CYCLES)
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	input wire logic trig_in_i,
	input wire logic switch_i,
	input wire logic sync_in_i,
	input wire logic tcode_in_i,
	output logic sync_arm_o,
	output logic led_flash_o,
	output logic frame_store_o,
	output logic [DEPTH_W-1:0] frame_addr_o,
	output logic [1:0] gain_step_o,
	output logic [7:0] black_level_o,
	output logic [7:0] contrast_reference_o,
	output logic [19:0] exposure_o,
	output logic [31:0] period_o
);
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [6:0] ctrl;
		logic [1:0] gain;
		logic [7:0] black;
		logic [7:0] contrast;
		logic [15:0] exp_val;
		logic [31:0] period_shadow;
		logic [31:0] period;
		logic [15:0] depth_shadow;
		logic [15:0] depth;
		logic [15:0] pretrig;
		logic [31:0] sync_tmo;
		rtsc_pkg::rtsc_rec_type rec;
		logic [2:0] trig_s;
		logic [2:0] sw_s;
		logic [2:0] sync_s;
		logic [2:0] tc_s;
		logic [31:0] frame_cnt;
		logic [31:0] exp_cnt;
		logic [31:0] tmo_cnt;
		logic timeout;
		logic [DEPTH_W-1:0] wr_ptr;
		logic [DEPTH_W-1:0] filled;
		logic [DEPTH_W-1:0] post_left;
		logic [31:0] stamp;
		logic [24:0] flash_cnt;
		logic expose;
		logic store;
		logic [31:0] tc_hi;
		logic [31:0] tc_len;
		logic tc_prev_mark;
		logic [6:0] tc_bit;
		logic [40:0] tc_sh;
		logic [29:0] tc_time;
		logic sec_mark;
	} rtsc_state_type;

	rtsc_state_type s_reg;
	rtsc_state_type s_next;

	logic wr;
	logic rd;
	logic trig_rise;
	logic sw_rise;
	logic sync_rise;
	logic tc_fall;
	logic host_start;
	logic host_stop;
	logic frame_tick;
	logic [31:0] exp_cyc;
	logic [31:0] tc_ms;

	always_comb begin
		// ----------------------------------------
		// bus access and input edges
		// ----------------------------------------
		wr = wb_cyc_i & wb_stb_i & wb_we_i & ~s_reg.ack;
		rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~s_reg.ack;
		trig_rise = s_reg.trig_s[1] & ~s_reg.trig_s[2];
		sw_rise = s_reg.sw_s[1] & ~s_reg.sw_s[2];
		sync_rise = s_reg.sync_s[1] & ~s_reg.sync_s[2];
		tc_fall = ~s_reg.tc_s[1] & s_reg.tc_s[2];
		host_start = wr & (wb_adr_i == rtsc_pkg::ADDR_CMD) & wb_sel_i[0] & wb_dat_i[rtsc_pkg::CMD_START];
		host_stop = wr & (wb_adr_i == rtsc_pkg::ADDR_CMD) & wb_sel_i[0] & wb_dat_i[rtsc_pkg::CMD_STOP];
		// low-light exposure is in ms, normal in us
		if (s_reg.ctrl[rtsc_pkg::CTRL_LOWLIGHT]) begin
			exp_cyc = 32'(s_reg.exp_val) * 32'(rtsc_pkg::MS_CYCLES);
		end else begin
			exp_cyc = 32'(s_reg.exp_val) * 32'(rtsc_pkg::US_CYCLES);
		end
		// sync-in frames follow the master alone; the free-running period is not used
		if (s_reg.ctrl[rtsc_pkg::CTRL_SYNC_IN]) begin
			frame_tick = sync_rise;
		end else begin
			frame_tick = (s_reg.frame_cnt >= s_reg.period - 32'h1) | s_reg.sec_mark;
		end
		tc_ms = s_reg.tc_len / 32'(rtsc_pkg::MS_CYCLES);

		s_next = s_reg;
		s_next.ack = wb_cyc_i & wb_stb_i & ~s_reg.ack;
		s_next.trig_s = {s_reg.trig_s[1:0], trig_in_i};
		s_next.sw_s = {s_reg.sw_s[1:0], switch_i};
		s_next.sync_s = {s_reg.sync_s[1:0], sync_in_i};
		s_next.tc_s = {s_reg.tc_s[1:0], tcode_in_i};
		s_next.sec_mark = 1'b0;
		s_next.store = 1'b0;

		// ----------------------------------------
		// register writes
		// ----------------------------------------
		if (wr & wb_sel_i[0]) begin
			unique case (wb_adr_i)
				rtsc_pkg::ADDR_CTRL: s_next.ctrl = wb_dat_i[6:0];
				rtsc_pkg::ADDR_GAIN: begin
					// top step refused on the 4x models, step 2 taken instead
					if (s_reg.ctrl[rtsc_pkg::CTRL_GAIN_LIMIT4] && wb_dat_i[1:0] == rtsc_pkg::GAIN_STEP_MAX) begin
						s_next.gain = 2'h2;
					end else begin
						s_next.gain = wb_dat_i[1:0];
					end
				end
				rtsc_pkg::ADDR_BLACK: s_next.black = wb_dat_i[7:0];
				rtsc_pkg::ADDR_CONTRAST: s_next.contrast = wb_dat_i[7:0];
				rtsc_pkg::ADDR_EXPOSURE: begin
					s_next.exp_val = wb_dat_i[15:0];
					if (wb_dat_i[15:0] > 16'(rtsc_pkg::LOWLIGHT_EXP_MAX_MS) && s_reg.ctrl[rtsc_pkg::CTRL_LOWLIGHT]) begin
						s_next.exp_val = 16'(rtsc_pkg::LOWLIGHT_EXP_MAX_MS);
					end
				end
				rtsc_pkg::ADDR_PERIOD: s_next.period_shadow = wb_dat_i;
				rtsc_pkg::ADDR_DEPTH: s_next.depth_shadow = wb_dat_i[15:0];
				rtsc_pkg::ADDR_PRETRIG: s_next.pretrig = wb_dat_i[15:0];
				rtsc_pkg::ADDR_SYNC_TMO: s_next.sync_tmo = wb_dat_i;
				rtsc_pkg::ADDR_APPLY: begin
					// apply invalidates the stored sequence
					s_next.period = s_reg.period_shadow;
					s_next.depth = s_reg.depth_shadow;
					s_next.rec = rtsc_pkg::REC_IDLE;
					s_next.filled = '0;
				end
				default: begin
				end
			endcase
		end
		// read data is registered so it stands with ack and holds until the next read
		if (rd) begin
			unique case (wb_adr_i)
				rtsc_pkg::ADDR_CTRL: s_next.rdata = {25'h0, s_reg.ctrl};
				rtsc_pkg::ADDR_GAIN: s_next.rdata = {30'h0, s_reg.gain};
				rtsc_pkg::ADDR_BLACK: s_next.rdata = {24'h0, s_reg.black};
				rtsc_pkg::ADDR_CONTRAST: s_next.rdata = {24'h0, s_reg.contrast};
				rtsc_pkg::ADDR_EXPOSURE: s_next.rdata = {16'h0, s_reg.exp_val};
				rtsc_pkg::ADDR_PERIOD: s_next.rdata = s_reg.period;
				rtsc_pkg::ADDR_DEPTH: s_next.rdata = {16'h0, s_reg.depth};
				rtsc_pkg::ADDR_PRETRIG: s_next.rdata = {16'h0, s_reg.pretrig};
				rtsc_pkg::ADDR_SYNC_TMO: s_next.rdata = s_reg.sync_tmo;
				rtsc_pkg::ADDR_STATUS: s_next.rdata = {27'h0, s_reg.timeout, 1'b0, s_reg.rec};
				rtsc_pkg::ADDR_STAMP: s_next.rdata = s_reg.stamp;
				rtsc_pkg::ADDR_TIME: s_next.rdata = {2'h0, s_reg.tc_time};
				default: s_next.rdata = '0;
			endcase
		end

		// ----------------------------------------
		// frame timebase and exposure
		// ----------------------------------------
		if (frame_tick) begin
			s_next.frame_cnt = '0;
			s_next.exp_cnt = '0;
			s_next.expose = 1'b1;
		end else begin
			s_next.frame_cnt = s_reg.frame_cnt + 32'h1;
			if (s_reg.expose) begin
				s_next.exp_cnt = s_reg.exp_cnt + 32'h1;
				if (s_reg.exp_cnt + 32'h1 >= exp_cyc) begin
					s_next.expose = 1'b0;
					s_next.store = 1'b1;
				end
			end
		end
		// missing master pulses stall capture and raise timeout
		if (!s_reg.ctrl[rtsc_pkg::CTRL_SYNC_IN] || sync_rise) begin
			s_next.tmo_cnt = '0;
			s_next.timeout = 1'b0;
		end else if (s_reg.tmo_cnt >= s_reg.sync_tmo) begin
			s_next.timeout = 1'b1;
		end else begin
			s_next.tmo_cnt = s_reg.tmo_cnt + 32'h1;
		end

		// ----------------------------------------
		// recording sequencer
		// ----------------------------------------
		unique case (s_reg.rec)
			rtsc_pkg::REC_IDLE, rtsc_pkg::REC_DONE: begin
				if (host_start || (sw_rise && s_reg.ctrl[rtsc_pkg::CTRL_CIRC])) begin
					s_next.ctrl[rtsc_pkg::CTRL_LOWLIGHT] = 1'b0;
					s_next.wr_ptr = '0;
					s_next.filled = '0;
					s_next.stamp = '0;
					s_next.rec = s_reg.ctrl[rtsc_pkg::CTRL_CIRC] ? rtsc_pkg::REC_ARMED : rtsc_pkg::REC_FILL;
				end
			end
			rtsc_pkg::REC_FILL: begin
				if (store_ok()) begin
					s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
					s_next.filled = s_reg.filled + 1'b1;
					if (s_reg.filled + 1'b1 >= DEPTH_W'(s_reg.depth)) begin
						s_next.rec = rtsc_pkg::REC_DONE;
					end
				end
			end
			rtsc_pkg::REC_ARMED: begin
				if (store_ok()) begin
					s_next.wr_ptr = (s_reg.wr_ptr + 1'b1 >= DEPTH_W'(s_reg.depth)) ? '0 : s_reg.wr_ptr + 1'b1;
				end
				if (sw_rise || trig_rise || host_stop) begin
					s_next.post_left = DEPTH_W'(s_reg.depth) - DEPTH_W'(s_reg.pretrig);
					s_next.stamp = '0;
					s_next.rec = rtsc_pkg::REC_POST;
				end else if (store_ok()) begin
					s_next.stamp = s_reg.stamp - 32'h1;
				end
			end
			rtsc_pkg::REC_POST: begin
				if (store_ok()) begin
					s_next.wr_ptr = (s_reg.wr_ptr + 1'b1 >= DEPTH_W'(s_reg.depth)) ? '0 : s_reg.wr_ptr + 1'b1;
					s_next.stamp = s_reg.stamp + 32'h1;
					s_next.post_left = s_reg.post_left - 1'b1;
					if (s_reg.post_left <= 1) begin
						s_next.rec = rtsc_pkg::REC_DONE;
					end
				end
			end
		endcase
		s_next.flash_cnt = (s_reg.rec == rtsc_pkg::REC_ARMED) ? s_reg.flash_cnt + 1'b1 : '0;

		// ----------------------------------------
		// time-code: pulse width per 10 ms bit cell
		// ----------------------------------------
		if (s_reg.ctrl[rtsc_pkg::CTRL_TCODE]) begin
			s_next.tc_len = s_reg.tc_len + 32'h1;
			if (s_reg.tc_s[1]) begin
				s_next.tc_hi = s_reg.tc_len + 32'h1;
			end
			if (s_reg.tc_len >= TCODE_BIT_CYC - 32'h1 || (tc_fall && s_reg.tc_len > 32'h1)) begin
				s_next.tc_len = '0;
			end
			if (tc_fall) begin
				// two marker cells in a row open a new second
				if (tc_ms >= 32'(rtsc_pkg::TCODE_MARK_MS)) begin
					if (s_reg.tc_prev_mark) begin
						s_next.tc_bit = '0;
						s_next.sec_mark = 1'b1;
						s_next.tc_time = {s_reg.tc_sh[40:31], s_reg.tc_sh[28:23], s_reg.tc_sh[16:10], s_reg.tc_sh[7:1]};
					end
					s_next.tc_prev_mark = 1'b1;
				end else begin
					s_next.tc_prev_mark = 1'b0;
					s_next.tc_sh = {(tc_ms >= 32'(rtsc_pkg::TCODE_ONE_MS)), s_reg.tc_sh[40:1]};
					s_next.tc_bit = s_reg.tc_bit + 7'h1;
				end
			end
		end

		if (rst_i) begin
			s_next = '0;
			s_next.gain = '0;
			s_next.black = rtsc_pkg::BLACK_RESET;
			s_next.contrast = rtsc_pkg::CONTRAST_RESET;
			s_next.exp_val = rtsc_pkg::EXP_RESET;
			s_next.period = rtsc_pkg::PERIOD_RESET;
			s_next.period_shadow = rtsc_pkg::PERIOD_RESET;
			s_next.depth = rtsc_pkg::DEPTH_RESET;
			s_next.depth_shadow = rtsc_pkg::DEPTH_RESET;
			s_next.pretrig = rtsc_pkg::PRETRIG_RESET;
			s_next.sync_tmo = rtsc_pkg::SYNC_TMO_RESET;
			s_next.rec = rtsc_pkg::REC_IDLE;
		end
	end

	function automatic logic store_ok();
		// capture halts while sync is timed out
		return s_reg.store & ~s_reg.timeout;
	endfunction : store_ok

	always_ff @(posedge clk_i) begin
		s_reg <= s_next;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign wb_ack_o = s_reg.ack;
	assign wb_dat_o = s_reg.rdata;
	assign sync_arm_o = s_reg.ctrl[rtsc_pkg::CTRL_OUT_ARM]
		? ((s_reg.rec == rtsc_pkg::REC_ARMED) ^ s_reg.ctrl[rtsc_pkg::CTRL_ARM_LOW])
		: s_reg.expose;
	assign led_flash_o = (s_reg.rec == rtsc_pkg::REC_ARMED) & s_reg.flash_cnt[24];
	assign frame_store_o = store_ok() & (s_reg.rec != rtsc_pkg::REC_IDLE) & (s_reg.rec != rtsc_pkg::REC_DONE);
	assign frame_addr_o = s_reg.wr_ptr;
	assign gain_step_o = s_reg.gain;
	assign black_level_o = s_reg.black;
	assign contrast_reference_o = s_reg.contrast;
	assign exposure_o = exp_cyc[19:0];
	assign period_o = s_reg.period;
endmodule : rtsc_top

//--- tb/rtsc_peer.sv
module rtsc_peer #(
	parameter int PER = 300
) (
	input wire logic clk_i,
	input wire logic run_i,
	output logic sync_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	initial sync_o = 1'b0;
	// master runs slower than the slave's own rate so the slave can lock
	always @(posedge clk_i) begin
		cnt <= (cnt >= PER - 1) ? 0 : cnt + 1;
		sync_o <= run_i && cnt < 4;
	end
endmodule : rtsc_peer

//--- tb/rtsc_top_bench.sv
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_mismatch++; \
	$display("unexpected %s exp %0h got %0h", n, e, s); end end
module rtsc_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0;
	logic rst_i = 1;
	logic [7:0] adr = 0;
	logic [31:0] wdat = 0;
	logic [31:0] rdat;
	logic [31:0] q = 0;
	logic we = 0;
	logic cyc = 0;
	logic stb = 0;
	logic ack;
	logic trig = 0;
	logic sw = 0;
	logic run = 0;
	logic sync;
	logic arm;
	logic store;
	logic led;
	logic [15:0] faddr;
	logic [1:0] gain;
	logic [7:0] black;
	logic [7:0] contr;
	logic [31:0] per;
	int n_mismatch = 0;
	int comparisons = 0;
	int n_store = 0;
	rtsc_top i_rtsc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .trig_in_i(trig),
		.switch_i(sw), .sync_in_i(sync), .tcode_in_i(1'b0), .sync_arm_o(arm), .led_flash_o(led),
		.frame_store_o(store), .frame_addr_o(faddr), .gain_step_o(gain), .black_level_o(black),
		.contrast_reference_o(contr), .exposure_o(), .period_o(per));
	rtsc_peer #(.PER(300)) i_rtsc_peer (.clk_i(clk_i), .run_i(run), .sync_o(sync));
	initial forever #10 clk_i = ~clk_i;
	// counted mid-cycle so the pulse is read while it stands, not at its launching edge
	always @(negedge clk_i) if (store === 1'b1) n_store++;
	// ----------------------------------------
	// bus and helpers
	// ----------------------------------------
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			i++;
		end while (ack !== 1'b1 && i < 50);
		if (ack !== 1'b1) n_mismatch++;
		q = rdat;
		cyc <= 0;
		stb <= 0;
	endtask : wb
	task wait_st(input logic [2:0] s);
		for (int i = 0; i < 3000 && (i == 0 || q[2:0] !== s); i++) wb(0, rtsc_pkg::ADDR_STATUS, 0);
	endtask : wait_st
	// inputs are held well past the two-flop sync so a slow edge still counts once
	task pulse(input int k);
		@(posedge clk_i);
		if (k == 0) sw <= 1;
		else trig <= 1;
		repeat (20) @(posedge clk_i);
		sw <= 0;
		trig <= 0;
	endtask : pulse
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		wb(0, rtsc_pkg::ADDR_BLACK, 0);
		`CHK("black reset", rtsc_pkg::BLACK_RESET, q[7:0])
		wb(0, 8'hfc, 0);
		`CHK("unmapped read", 32'h0, q)
		wb(1, rtsc_pkg::ADDR_BLACK, 32'hff);
		`CHK("black level", rtsc_pkg::BLACK_MAX, black)
		wb(1, rtsc_pkg::ADDR_CONTRAST, 32'h5a);
		`CHK("contrast", 8'h5a, contr)
		for (int g = 0; g < 4; g++) begin
			wb(1, rtsc_pkg::ADDR_GAIN, 32'(g));
			`CHK("gain step", 2'(g), gain)
		end
		wb(1, rtsc_pkg::ADDR_CTRL, 32'h1 << rtsc_pkg::CTRL_GAIN_LIMIT4);
		wb(1, rtsc_pkg::ADDR_GAIN, 32'h3);
		`CHK("gain limit", 2'h2, gain)
		wb(1, rtsc_pkg::ADDR_PERIOD, 32'hc8);
		wb(1, rtsc_pkg::ADDR_DEPTH, 32'h4);
		wb(1, rtsc_pkg::ADDR_PRETRIG, 32'h1);
		wb(1, rtsc_pkg::ADDR_EXPOSURE, 32'h1);
		`CHK("period held", rtsc_pkg::PERIOD_RESET, per)
		wb(1, rtsc_pkg::ADDR_APPLY, 32'h1);
		`CHK("period applied", 32'hc8, per)
	endtask : t_regs
	task t_noncirc;
		wb(1, rtsc_pkg::ADDR_CTRL, 32'h1 << rtsc_pkg::CTRL_LOWLIGHT);
		pulse(0);
		pulse(1);
		wb(0, rtsc_pkg::ADDR_STATUS, 0);
		`CHK("state after inputs", rtsc_pkg::REC_IDLE, q[2:0])
		n_store = 0;
		wb(1, rtsc_pkg::ADDR_CMD, 32'h1);
		wait_st(rtsc_pkg::REC_DONE);
		`CHK("fill state", rtsc_pkg::REC_DONE, q[2:0])
		`CHK("fill frames", 4, n_store)
		`CHK("fill address", 16'h4, faddr)
		wb(0, rtsc_pkg::ADDR_CTRL, 0);
		`CHK("low light", 1'b0, q[rtsc_pkg::CTRL_LOWLIGHT])
	endtask : t_noncirc
	task t_circ;
		for (int k = 0; k < 3; k++) begin
			wb(1, rtsc_pkg::ADDR_CTRL, 32'h9);
			wb(1, rtsc_pkg::ADDR_APPLY, 32'h1);
			if (k == 0) pulse(0);
			else wb(1, rtsc_pkg::ADDR_CMD, 32'h1);
			wait_st(rtsc_pkg::REC_ARMED);
			`CHK("armed", rtsc_pkg::REC_ARMED, q[2:0])
			`CHK("ready pin", 1'b1, arm)
			n_store = 0;
			if (k == 2) wb(1, rtsc_pkg::ADDR_CMD, 32'h2);
			else pulse(k);
			wait_st(rtsc_pkg::REC_DONE);
			`CHK("triggered", rtsc_pkg::REC_DONE, q[2:0])
			`CHK("post frames", 3, n_store)
			`CHK("ready pin off", 1'b0, arm)
			`CHK("led stopped", 1'b0, led)
		end
		wb(1, rtsc_pkg::ADDR_CTRL, 32'h19);
		`CHK("ready active low", 1'b1, arm)
	endtask : t_circ
	task t_sync;
		wb(1, rtsc_pkg::ADDR_SYNC_TMO, 32'h12c);
		wb(1, rtsc_pkg::ADDR_CTRL, 32'h1 << rtsc_pkg::CTRL_SYNC_IN);
		wb(1, rtsc_pkg::ADDR_APPLY, 32'h1);
		n_store = 0;
		wb(1, rtsc_pkg::ADDR_CMD, 32'h1);
		q = 0;
		for (int i = 0; i < 300 && q[4] !== 1'b1; i++) wb(0, rtsc_pkg::ADDR_STATUS, 0);
		`CHK("sync timeout", 1'b1, q[4])
		`CHK("no frames", 0, n_store)
		run <= 1;
		wb(1, rtsc_pkg::ADDR_APPLY, 32'h1);
		wb(1, rtsc_pkg::ADDR_CMD, 32'h1);
		wait_st(rtsc_pkg::REC_DONE);
		`CHK("synced record", rtsc_pkg::REC_DONE, q[2:0])
		`CHK("synced frames", 4, n_store)
	endtask : t_sync
	task tally_and_finish;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		#400000;
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		t_regs();
		t_noncirc();
		t_circ();
		t_sync();
		tally_and_finish();
	end
endmodule : rtsc_top_bench

//--- tb/rtsc_top_chk.sv
module rtsc_top_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [1:0] gain_step_o,
	input wire logic [7:0] black_level_o,
	input wire logic [7:0] contrast_reference_o,
	input wire logic [31:0] period_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic take;
	logic wr;
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = take && wb_we_i && wb_sel_i[0];
	// ----------------------------------------
	// bus timing and host-side parameters
	// ----------------------------------------
	property p_ack; take |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("request not acknowledged");
	property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
	property p_no_req; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
	a_no_req: assert property (p_no_req) else $error("ack without request");
	property p_unmapped; take && !wb_we_i && wb_adr_i == 8'hfc |=> wb_dat_o == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_black; wr && wb_adr_i == rtsc_pkg::ADDR_BLACK |=> black_level_o == $past(wb_dat_i[7:0]); endproperty
	a_black: assert property (p_black) else $error("black level not taken");
	property p_contrast; wr && wb_adr_i == rtsc_pkg::ADDR_CONTRAST |=> contrast_reference_o == $past(wb_dat_i[7:0]);
	endproperty
	a_contrast: assert property (p_contrast) else $error("contrast not taken at once");
	property p_gain; wr && wb_adr_i == rtsc_pkg::ADDR_GAIN && wb_dat_i[1:0] != 2'h3 ##1 1 |-> gain_step_o ==
		$past(wb_dat_i[1:0]); endproperty
	a_gain: assert property (p_gain) else $error("gain step not taken");
	// shadowed rate must never move except on the apply write
	property p_period; $changed(period_o) |-> $past(wr) && $past(wb_adr_i) == rtsc_pkg::ADDR_APPLY; endproperty
	a_period: assert property (p_period) else $error("period changed without apply");
endmodule : rtsc_top_chk

bind rtsc_top rtsc_top_chk i_rtsc_top_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .gain_step_o(gain_step_o), .black_level_o(black_level_o),
	.contrast_reference_o(contrast_reference_o), .period_o(period_o));
